// ===== watch_timer_pkg.sv
// Package of constants shared by the watch/interval timer and its tick source.
// Assumes a single 10 MHz system clock and an APB register interface with 32-bit data.
`default_nettype none

package watch_timer_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Clocking and tick source.
    localparam int unsigned CLK_FREQ_HZ     = 10_000_000;  // System clock rate.
    localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_FREQ_HZ;
    localparam int unsigned MAIN_DIV        = 128;         // Main clock divider for the tick.
    localparam int unsigned TICK_MAIN_HZ    = CLK_FREQ_HZ / MAIN_DIV;  // 78.125 kHz.

    ////////////////////////////////////////////////////////////////////////////////
    // Counter geometry.
    localparam int unsigned PRESC_W         = 11;  // Prescaler width.
    localparam int unsigned WCNT_W          = 5;   // Watch counter width.
    localparam int unsigned WCNT_TAP        = 9;   // Watch counter advances every 2^9 ticks.
    localparam int unsigned IVL_MIN_EXP     = 4;   // Interval code 0 is 2^4 ticks.
    localparam int unsigned IVL_CODES       = 8;   // Interval codes 0..7 give 2^4..2^11.
    localparam logic [4:0]  WCNT_FULL       = 5'h1F;  // Wrap for the 2^14 period.
    localparam logic [3:0]  WCNT_HALF       = 4'hF;   // Wrap for the 2^13 period.

    ////////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses.
    localparam logic [11:0] OFF_MODE        = 12'h000;  // Watch mode register.
    localparam logic [11:0] OFF_STATUS      = 12'h004;  // Sticky event flags, write one to clear.
    localparam logic [11:0] OFF_MASK        = 12'h008;  // Interrupt enables.
    localparam logic [11:0] OFF_COUNT       = 12'h00C;  // Live counter state, read only.

    // Mode register fields.
    localparam int unsigned MODE_RUN_BIT    = 0;  // run_enable.
    localparam int unsigned MODE_START_BIT  = 1;  // counter_start.
    localparam int unsigned MODE_ISEL_LSB   = 2;  // interrupt_sel_lo, interrupt_sel_hi.
    localparam int unsigned MODE_VSEL_LSB   = 4;  // interval_sel_b0..b2.
    localparam int unsigned MODE_CSEL_BIT   = 7;  // clock_sel.
    localparam logic [7:0]  MODE_RESET      = 8'h00;

    // Status and mask fields.
    localparam int unsigned EVT_WATCH_BIT   = 0;
    localparam int unsigned EVT_IVL_BIT     = 1;
    localparam logic [1:0]  STATUS_RESET    = 2'h0;
    localparam logic [1:0]  MASK_RESET      = 2'h0;

    // Count register fields.
    localparam int unsigned CNT_PRESC_LSB   = 0;
    localparam int unsigned CNT_WCNT_LSB    = 11;
    localparam int unsigned CNT_ARMED_BIT   = 16;

    // Interrupt period codes of the watch output.
    localparam logic [1:0]  ISEL_P14        = 2'h0;
    localparam logic [1:0]  ISEL_P13        = 2'h1;
    localparam logic [1:0]  ISEL_P5         = 2'h2;
    localparam logic [1:0]  ISEL_P4         = 2'h3;

endpackage

`default_nettype wire

// ===== watch_tick_gen.sv
// Tick source of the watch timer: a one-cycle tick per tick-clock period.
// Assumes the subsystem oscillator level arrives synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

module watch_tick_gen
    import watch_timer_pkg::*;
#(
    parameter int unsigned DIV = MAIN_DIV  // Main clock divider, a power of two.
) (
    input  wire logic clk_i,      // System clock.
    input  wire logic sys_rst_i,  // Synchronous reset, active high.
    input  wire logic clock_sel_i,// 1 picks the subsystem oscillator.
    input  wire logic sub_osc_i,  // Subsystem oscillator level.
    output logic      tick_o      // One-cycle tick pulse.
);

    localparam int unsigned DW = $clog2(DIV);

    generate
        if (DIV < 2 || (DIV & (DIV - 1)) != 0) begin : g_bad_div
            $error("watch_tick_gen: DIV must be a power of two of at least 2.");
        end
    endgenerate

    typedef struct packed {
        logic [DW-1:0] div;
        logic          sub_prev;
        logic          tick;
    } tick_state_t;

    tick_state_t s_q;
    tick_state_t s_d;

    ////////////////////////////////////////////////////////////////////////////////
    // The divider runs freely so a switch of source never has to wait for a restart.
    always_comb begin
        s_d          = s_q;
        s_d.div      = s_q.div + 1'b1;
        s_d.sub_prev = sub_osc_i;
        if (clock_sel_i) begin
            s_d.tick = sub_osc_i & ~s_q.sub_prev;
        end else begin
            s_d.tick = (s_q.div == {DW{1'b1}});
        end
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_o = s_q.tick;

endmodule

`default_nettype wire

// ===== watch_interval_timer.sv
// Watch timer with an interval timer, both driven by one selectable tick clock.
// Assumes an APB master on the system clock; the subsystem oscillator level is
// already synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Watch counting needs run_enable and counter_start.
// - Both cleared: clear and stop watch counter.
// - counter_start low clears counter, prescaler keeps running.
// - interrupt_sel picks 2^14, 2^13, 2^5, 2^4.
// - interval_irq repeats, independent of watch function.
// - interval_sel picks 2^4 through 2^11 ticks.
// - Interval counts while run_enable, ignoring counter_start.
// - First watch_irq at 2^14 or 2^13 late by one tap period.
// - clock_sel high selects subsystem oscillator tick.
// - run_enable low zeroes prescaler and counter.
// - clock_sel low: main clock divided by 128.
// - Reset clears the whole mode register.
module watch_interval_timer
    import watch_timer_pkg::*;
#(
    parameter int unsigned ADDR_W = 12  // APB address width.
) (
    input  wire logic              clk_i,            // System clock, 10 MHz.
    input  wire logic              sys_rst_i,        // Synchronous reset, active high.
    input  wire logic              sub_osc_i,        // Subsystem oscillator level.
    input  wire logic              psel_i,           // APB select.
    input  wire logic              penable_i,        // APB enable.
    input  wire logic              pwrite_i,         // APB direction, 1 is write.
    input  wire logic [ADDR_W-1:0] paddr_i,          // APB byte address.
    input  wire logic [31:0]       pwdata_i,         // APB write data.
    input  wire logic [3:0]        pstrb_i,          // APB byte strobes.
    output logic      [31:0]       prdata_o,         // APB read data.
    output logic                   pready_o,         // APB ready.
    output logic                   pslverr_o,        // APB error for unmapped access.
    output logic                   watch_irq_o,      // Watch request pulse.
    output logic                   interval_irq_o,   // Interval request pulse.
    output logic                   irq_o             // Masked interrupt level.
);

    generate
        // The register offsets are cut to ADDR_W bits, so wider buses cannot be served.
        if (ADDR_W < 4 || ADDR_W > 12) begin : g_bad_addr
            $error("watch_interval_timer: ADDR_W must be from 4 to 12.");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Whole state of the block, registered in one place.
    typedef struct packed {
        logic [7:0]         mode;
        logic [1:0]         status;
        logic [1:0]         mask;
        logic [PRESC_W-1:0] presc;
        logic [WCNT_W-1:0]  wcnt;
        logic               armed;
        logic               watch_pulse;
        logic               ivl_pulse;
        logic               irq;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
    } timer_state_t;

    timer_state_t s_q;
    timer_state_t s_d;

    logic                 tick;
    logic [IVL_CODES-1:0] ivl_hit;
    logic                 wtap_hit;

    ////////////////////////////////////////////////////////////////////////////////
    // Tick source; the mode register steers which clock feeds the counters.
    watch_tick_gen #(
        .DIV (MAIN_DIV)
    ) u_tick (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .clock_sel_i (s_q.mode[MODE_CSEL_BIT]),
        .sub_osc_i   (sub_osc_i),
        .tick_o      (tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Prescaler taps: tap k fires on the tick that carries the low 4+k bits over,
    // so it repeats every 2^(4+k) ticks.
    genvar k;
    generate
        for (k = 0; k < IVL_CODES; k++) begin : g_tap
            assign ivl_hit[k] = &s_q.presc[IVL_MIN_EXP+k-1:0];
        end
    endgenerate

    // The watch counter steps on the 2^9 tap.
    assign wtap_hit = &s_q.presc[WCNT_TAP-1:0];

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic: counters, events, sticky flags and the APB slave.
    always_comb begin
        logic              run;
        logic              start;
        logic [1:0]        isel;
        logic [2:0]        vsel;
        logic              watch_evt;
        logic              ivl_evt;
        logic              wrap;
        logic              access;
        logic              done;
        logic              hit_mode;
        logic              hit_status;
        logic              hit_mask;
        logic              hit_count;
        logic              mapped;
        logic [ADDR_W-1:0] off;
        logic [1:0]        w1c;
        logic [31:0]       rdata;

        s_d        = s_q;
        run        = s_q.mode[MODE_RUN_BIT];
        start      = s_q.mode[MODE_START_BIT];
        isel       = s_q.mode[MODE_ISEL_LSB +: 2];
        vsel       = s_q.mode[MODE_VSEL_LSB +: 3];
        watch_evt  = 1'b0;
        ivl_evt    = 1'b0;
        wrap       = 1'b0;
        w1c        = 2'h0;
        rdata      = 32'h0000_0000;
        access     = 1'b0;
        done       = 1'b0;
        hit_mode   = 1'b0;
        hit_status = 1'b0;
        hit_mask   = 1'b0;
        hit_count  = 1'b0;
        mapped     = 1'b0;
        off        = '0;

        // Prescaler runs while enabled and is held at zero otherwise.
        if (!run) begin
            s_d.presc = '0;
        end else if (tick) begin
            s_d.presc = s_q.presc + 1'b1;
        end

        // Interval event: one pulse per selected tap period, watch state ignored.
        ivl_evt = run & tick & ivl_hit[vsel];

        // Watch counter. The first 2^9 tap after a start only arms the counter,
        // which is why the first 2^14 or 2^13 request comes one tap period late.
        if (!(run && start)) begin
            s_d.wcnt  = '0;
            s_d.armed = 1'b0;
        end else if (tick && wtap_hit) begin
            if (!s_q.armed) begin
                s_d.armed = 1'b1;
            end else begin
                s_d.wcnt = s_q.wcnt + 1'b1;
            end
        end

        // Watch period select. The short periods come straight from the prescaler.
        case (isel)
            ISEL_P14: begin
                wrap = (s_q.wcnt == WCNT_FULL);
            end
            ISEL_P13: begin
                wrap = (s_q.wcnt[3:0] == WCNT_HALF);
            end
            ISEL_P5: begin
                wrap = ivl_hit[1];
            end
            ISEL_P4: begin
                wrap = ivl_hit[0];
            end
            default: begin
                wrap = 1'b0;
            end
        endcase
        if (isel == ISEL_P14 || isel == ISEL_P13) begin
            watch_evt = run & start & tick & wtap_hit & s_q.armed & wrap;
        end else begin
            watch_evt = run & start & tick & wrap;
        end

        s_d.watch_pulse = watch_evt;
        s_d.ivl_pulse   = ivl_evt;

        // APB decode. Only aligned words inside the map are accepted.
        off        = paddr_i;
        hit_mode   = (off == OFF_MODE[ADDR_W-1:0]);
        hit_status = (off == OFF_STATUS[ADDR_W-1:0]);
        hit_mask   = (off == OFF_MASK[ADDR_W-1:0]);
        hit_count  = (off == OFF_COUNT[ADDR_W-1:0]);
        mapped     = hit_mode | hit_status | hit_mask | hit_count;
        access     = psel_i & penable_i;
        done       = access & s_q.pready;

        // One wait state: ready rises in the second access cycle and drops after.
        s_d.pready  = access & ~s_q.pready;
        s_d.pslverr = access & ~s_q.pready & ~mapped;

        // Read data are captured with ready so they come out of a register.
        if (hit_mode) begin
            rdata[7:0] = s_q.mode;
        end else if (hit_status) begin
            rdata[1:0] = s_q.status;
        end else if (hit_mask) begin
            rdata[1:0] = s_q.mask;
        end else if (hit_count) begin
            rdata[CNT_PRESC_LSB +: PRESC_W] = s_q.presc;
            rdata[CNT_WCNT_LSB +: WCNT_W]   = s_q.wcnt;
            rdata[CNT_ARMED_BIT]            = s_q.armed;
        end
        if (access && !s_q.pready && !pwrite_i) begin
            s_d.prdata = rdata;
        end else if (done) begin
            s_d.prdata = 32'h0000_0000;
        end

        // Writes take effect at the completing edge; only byte lane 0 holds bits.
        if (done && pwrite_i && pstrb_i[0]) begin
            if (hit_mode) begin
                s_d.mode = pwdata_i[7:0];
            end
            if (hit_mask) begin
                s_d.mask = pwdata_i[1:0];
            end
            if (hit_status) begin
                w1c = pwdata_i[1:0];
            end
        end

        // Sticky flags: a new event beats a clear in the same cycle.
        s_d.status = s_q.status & ~w1c;
        s_d.status[EVT_WATCH_BIT] = s_d.status[EVT_WATCH_BIT] | watch_evt;
        s_d.status[EVT_IVL_BIT]   = s_d.status[EVT_IVL_BIT] | ivl_evt;
        s_d.irq = |(s_d.status & s_d.mask);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register; reset leaves both functions stopped.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_q        <= '0;
            s_q.mode   <= MODE_RESET;
            s_q.status <= STATUS_RESET;
            s_q.mask   <= MASK_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs come straight from the state register.
    assign prdata_o       = s_q.prdata;
    assign pready_o       = s_q.pready;
    assign pslverr_o      = s_q.pslverr;
    assign watch_irq_o    = s_q.watch_pulse;
    assign interval_irq_o = s_q.ivl_pulse;
    assign irq_o          = s_q.irq;

endmodule

`default_nettype wire

// ===== wit_assertions.sv
// Checker of the watch/interval timer as seen at its ports.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none

module wit_checker
    import watch_timer_pkg::*;
#(
    parameter int unsigned ADDR_W = 12  // Address width.
) (
    input wire logic              clk_i,          // Clock.
    input wire logic              sys_rst_i,      // Reset.
    input wire logic              psel_i,         // Select.
    input wire logic              penable_i,      // Enable.
    input wire logic              pwrite_i,       // Direction.
    input wire logic [ADDR_W-1:0] paddr_i,        // Address.
    input wire logic [31:0]       pwdata_i,       // Write data.
    input wire logic [3:0]        pstrb_i,        // Strobes.
    input wire logic [31:0]       prdata_o,       // Read data.
    input wire logic              pready_o,       // Ready.
    input wire logic              pslverr_o,      // Error.
    input wire logic              watch_irq_o,    // Watch pulse.
    input wire logic              interval_irq_o, // Interval pulse.
    input wire logic              irq_o           // Interrupt level.
);
    logic [7:0] ivl_gap_q;  // Cycles since the last interval pulse.
    logic [7:0] wat_gap_q;  // Cycles since the last watch pulse.

    ////////////////////////////////////////
    // Saturating gap counters; saturation keeps the first pulse after reset legal.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ivl_gap_q <= 8'hFF;
            wat_gap_q <= 8'hFF;
        end else begin
            ivl_gap_q <= interval_irq_o ? 8'h00 : ivl_gap_q + {7'h00, ivl_gap_q != 8'hFF};
            wat_gap_q <= watch_irq_o ? 8'h00 : wat_gap_q + {7'h00, wat_gap_q != 8'hFF};
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    ////////////////////////////////////////
    // A tick comes at most every second cycle, so the shortest period is 32 cycles.
    sequence s_stop_wr;
        psel_i && penable_i && pready_o && pwrite_i && paddr_i == ADDR_W'(OFF_MODE) && pstrb_i[0] && !pwdata_i[0];
    endsequence
    sequence s_acc;
        psel_i && $rose(penable_i);
    endsequence
    property p_rst_quiet;
        disable iff (1'b0) sys_rst_i |=> !(watch_irq_o || interval_irq_o || irq_o || pready_o);
    endproperty
    property p_wat_pulse; watch_irq_o |=> !watch_irq_o; endproperty
    property p_ivl_pulse; interval_irq_o |=> !interval_irq_o; endproperty
    property p_ivl_gap; interval_irq_o |-> ivl_gap_q >= 8'h1F; endproperty
    property p_wat_gap; watch_irq_o |-> wat_gap_q >= 8'h1F; endproperty
    property p_stop_quiet; s_stop_wr |-> ##2 (!interval_irq_o && !watch_irq_o) [*8]; endproperty
    property p_rdy_wait; s_acc |-> !pready_o ##1 pready_o; endproperty
    property p_err_rdy; pslverr_o |-> pready_o; endproperty
    property p_rd_idle; !pready_o |-> prdata_o == 32'h0; endproperty

    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs active after reset");
    a_wat_pulse: assert property (p_wat_pulse)
        else $error("watch pulse longer than one cycle");
    a_ivl_pulse: assert property (p_ivl_pulse)
        else $error("interval pulse longer than one cycle");
    a_ivl_gap: assert property (p_ivl_gap)
        else $error("interval pulses too close");
    a_wat_gap: assert property (p_wat_gap)
        else $error("watch pulses too close");
    a_stop_quiet: assert property (p_stop_quiet)
        else $error("pulse after run was cleared");
    a_rdy_wait: assert property (p_rdy_wait)
        else $error("ready not in second access cycle");
    a_err_rdy: assert property (p_err_rdy)
        else $error("error without ready");
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero while idle");
endmodule

bind watch_interval_timer wit_checker #(.ADDR_W(ADDR_W)) u_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .watch_irq_o(watch_irq_o), .interval_irq_o(interval_irq_o), .irq_o(irq_o)
);

`default_nettype wire

// ===== watch_interval_timer_test.sv
// Self-checking bench of the watch/interval timer.
// Assumes one APB wait state and a tick on every second cycle from sub_osc_i.
`timescale 1ns/1ps
`default_nettype none

module watch_interval_timer_test;
    import watch_timer_pkg::*;
    typedef struct {bit rel; int gap;} note_t;  // Watch gap from last watch, or last interval if rel.
    logic        clk_i     = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        sub_osc_i = 1'b0;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [11:0] paddr_i   = 12'h000;
    logic [31:0] pwdata_i  = 32'h0;
    logic [3:0]  pstrb_i   = 4'hF;
    wire  [31:0] prdata_o;
    wire         pready_o, pslverr_o, watch_irq_o, interval_irq_o, irq_o;
    int          err_count = 0, num_checks = 0, cyc = 0, last_i = 0, last_w = 0;
    int          seed = 32'hBD453BD6;
    logic [32:0] q_r[$];
    int          q_i[$];
    note_t       q_w[$];
    note_t       wn;

    watch_interval_timer dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sub_osc_i(sub_osc_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .watch_irq_o(watch_irq_o), .interval_irq_o(interval_irq_o), .irq_o(irq_o));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    // The subsystem oscillator toggles every cycle, giving one tick per two cycles.
    always @(posedge clk_i) sub_osc_i <= ~sub_osc_i;

    ////////////////////////////////////////
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One APB transfer; the note is the expected error bit and read data.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        int n;
        q_r.push_back(e);
        @(posedge clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            close_out;
        end
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic waitp(input bit w, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ((w ? watch_irq_o : interval_irq_o) !== 1'b1 && n < lim);
        if (n >= lim) begin
            err_count++;
            close_out;
        end
    endtask

    // Start a mode, skip the first pulse, then expect two periods of g cycles.
    task automatic run(input bit w, input logic [31:0] m, input int g);
        apb(1'b1, OFF_MODE, m, 33'h0);
        waitp(w, 3 * g);
        @(posedge clk_i);
        repeat (2) if (w) q_w.push_back('{1'b0, g}); else q_i.push_back(g);
        repeat (2) waitp(w, 3 * g);
        apb(1'b1, OFF_MODE, 32'h0, 33'h0);
    endtask

    ////////////////////////////////////////
    // Watcher: each answer, and each pulse that finds a note queued, takes the oldest note and compares against it.
    always @(posedge clk_i) begin
        cyc++;
        if (!sys_rst_i && pready_o === 1'b1 && q_r.size() > 0)
            chk(pwrite_i ? {pslverr_o, 32'h0} : {pslverr_o, prdata_o}, q_r.pop_front());
        if (interval_irq_o === 1'b1) begin
            if (q_i.size() > 0) chk(33'(cyc - last_i), 33'(q_i.pop_front()));
            last_i = cyc;
        end
        if (watch_irq_o === 1'b1) begin
            if (q_w.size() > 0) begin
                wn = q_w.pop_front();
                chk(33'(cyc - (wn.rel ? last_i : last_w)), 33'(wn.gap));
            end
            last_w = cyc;
        end
    end

    ////////////////////////////////////////
    initial begin
        logic [31:0] d;
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (int k = 0; k < 4; k++) apb(1'b0, 12'(k * 4), 32'h0, 33'h0);
        apb(1'b1, 12'h010, $random(seed), {1'b1, 32'h0});
        apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
        d = $random(seed);
        d[7:0] = 8'h7C;
        apb(1'b1, OFF_MODE, d, 33'h0);
        apb(1'b0, OFF_MODE, 32'h0, 33'h07C);
        // Every interval code, with counter_start left clear.
        for (int s = 0; s < 8; s++) run(1'b0, 32'h81 | 32'(s << 4), 2 << (4 + s));
        for (int c = 2; c < 4; c++) run(1'b1, 32'h83 | 32'(c << 2), 2 << (7 - c));
        run(1'b0, 32'h01, 2048);
        // Run without start: only the interval event may set status.
        apb(1'b1, OFF_STATUS, 32'h3, 33'h0);
        apb(1'b1, OFF_MODE, 32'h8D, 33'h0);
        repeat (3) waitp(1'b0, 200);
        apb(1'b1, OFF_MODE, 32'h0, 33'h0);
        apb(1'b0, OFF_STATUS, 32'h0, 33'h2);
        chk(33'(irq_o), 33'h0);
        apb(1'b1, OFF_MASK, 32'h2, 33'h0);
        repeat (2) @(negedge clk_i);
        chk(33'(irq_o), 33'h1);
        apb(1'b1, OFF_STATUS, 32'h2, 33'h0);
        repeat (2) @(negedge clk_i);
        chk(33'(irq_o), 33'h0);
        apb(1'b0, OFF_MASK, 32'h0, 33'h2);
        // Watch at 2^13 with the arm delay, timed against interval pulses at 2^11.
        repeat (2) q_w.push_back('{1'b1, 1024});
        apb(1'b1, OFF_MODE, 32'hF7, 33'h0);
        repeat (2) waitp(1'b1, 20000);
        apb(1'b1, OFF_MODE, 32'h0, 33'h0);
        apb(1'b0, OFF_COUNT, 32'h0, 33'h0);
        // A reset in mid-run clears the mode register.
        apb(1'b1, OFF_MODE, 32'h81, 33'h0);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        apb(1'b0, OFF_MODE, 32'h0, 33'h0);
        close_out;
    end
endmodule

`default_nettype wire
